// ---- hw/nlh_host_port.sv ----
// host controller driving the flash disk's strobe bus, plain or multiplexed
//
// Notes on behaviour
// - write happens only while chip select and write strobe are both low.
// - read happens only while chip select and output strobe are both low.
// - multiplexed: address bits 12..1 sit on lines 11..0 while address valid and chip select are both low.
// - that falling edge comes after reset release and before the first access.
// - deep sleep input enters and leaves deep power-down on the address bit 0 pin in 16-bit mode only.
// - device holds busy low while initialising; no access until released.
`include "nlh_defs.svh"
`default_nettype none
module nlh_host_port
  import nlh_pkg::*;
#(
  parameter int RST_CYC = `NLH_CYC(`NLH_RST_PULSE_NS)
) (
  input wire logic clk, // 40 MHz
  input wire logic rst_b, // synchronous, active low
  input wire logic ena, // freezes all state while low
  input wire logic cfg_mux, // use multiplexed address/data
  input wire logic cfg_wide, // 1: 16-bit access, 0: 8-bit
  input wire logic cfg_lock, // request hardware protection lock
  input wire logic sleep_req, // level: deep power-down wanted
  input wire logic req_valid, // access request
  output logic req_ready, // request taken when high with req_valid
  input wire logic req_write, // 1 write, 0 read
  input wire logic [`NLH_ADDR_W-1:0] req_addr, // byte address in the window
  input wire logic [`NLH_DATA_W-1:0] req_wdata, // write data
  output logic rsp_valid, // one-cycle pulse at end of access
  output logic [`NLH_DATA_W-1:0] rsp_rdata, // read data, registered
  output logic dev_ready, // device initialised and usable
  output logic irq_seen, // registered interrupt level
  output logic dma_seen, // registered dma request level
  output logic reset_in_n, // device reset
  output logic ce_n, // chip select
  output logic we_n, // write strobe
  output logic oe_n, // output strobe
  output logic address_valid_n, // drives device identity_bit_hi
  output logic [`NLH_ADDR_W-1:1] addr_hi, // plain-mode address 12..1
  output logic addr_lsb, // address bit 0 or deep_sleep_ctl
  output logic if_cfg, // width select pin
  output logic lock_n, // hardware lock pin
  output logic [`NLH_DATA_W-1:0] ad_out, // shared lines, out
  output logic [`NLH_DATA_W-1:0] ad_oe, // shared lines, enable per bit
  input wire logic [`NLH_DATA_W-1:0] ad_in, // shared lines, in
  input wire logic busy_n, // open-drain busy, read level
  input wire logic irq_n, // open-drain interrupt
  input wire logic dma_request_n // open-drain dma request
);
  localparam logic [7:0] C_RST = 8'(RST_CYC - 1);
  localparam logic [7:0] C_AVD = 8'(`NLH_CYC(`NLH_AVD_NS) - 1);
  localparam logic [7:0] C_SETUP = 8'(`NLH_CYC(`NLH_SETUP_NS) - 1);
  localparam logic [7:0] C_STB = 8'(`NLH_CYC(`NLH_ACCESS_NS) - 1);
  localparam logic [7:0] C_HOLD = 8'(`NLH_CYC(`NLH_HOLD_NS) - 1);

  nlh_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [`NLH_ADDR_W-1:0] addr_reg, addr_next;
  logic [`NLH_DATA_W-1:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic write_reg, write_next, mux_reg, mux_next, wide_reg, wide_next;
  logic sleep_reg, sleep_next, lock_reg, lock_next, irq_reg, irq_next, dma_reg, dma_next;
  logic cnt_done;

  assign cnt_done = (cnt_reg == 8'h00);

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_done ? 8'h00 : cnt_reg - 8'h01;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    write_next = write_reg;
    mux_next = mux_reg;
    wide_next = wide_reg;
    sleep_next = sleep_reg;
    lock_next = cfg_lock;
    irq_next = !irq_n;
    dma_next = !dma_request_n;
    case (state_reg)
      NLH_RST: begin
        // mode straps are caught while reset is driven, not while rst_b is low
        mux_next = cfg_mux;
        wide_next = cfg_wide;
        if (cnt_done) begin
          state_next = NLH_BUSYW;
        end
      end
      NLH_BUSYW: begin
        // the device holds busy low from its reset on, so the first high level ends init
        if (busy_n) begin
          state_next = mux_reg ? NLH_MUXSEL : NLH_IDLE;
          cnt_next = C_AVD;
        end
      end
      NLH_MUXSEL: begin
        // one falling edge on the identity line before any access
        if (cnt_done) begin
          state_next = NLH_IDLE;
        end
      end
      NLH_IDLE: begin
        sleep_next = sleep_req;
        if (req_valid && !sleep_reg && !sleep_req) begin
          addr_next = req_addr;
          wdata_next = req_wdata;
          write_next = req_write;
          state_next = mux_reg ? NLH_ADDR : NLH_SETUP;
          cnt_next = mux_reg ? C_AVD : C_SETUP;
        end
      end
      NLH_ADDR: begin
        if (cnt_done) begin
          state_next = NLH_SETUP;
          cnt_next = C_SETUP;
        end
      end
      NLH_SETUP: begin
        if (cnt_done) begin
          state_next = NLH_STROBE;
          cnt_next = C_STB;
        end
      end
      NLH_STROBE: begin
        if (cnt_done) begin
          // narrow mode: upper lines float on the pull-ups, so mask them
          // writes leave the last read word in place for the user
          if (!write_reg) begin
            rdata_next = wide_reg ? ad_in : {8'h00, ad_in[7:0]};
          end
          state_next = NLH_HOLD;
          cnt_next = C_HOLD;
        end
      end
      NLH_HOLD: begin
        if (cnt_done) begin
          state_next = NLH_IDLE;
        end
      end
      default: begin
        state_next = NLH_RST;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= NLH_RST;
      cnt_reg <= C_RST;
      addr_reg <= 13'h0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      write_reg <= 1'b0;
      mux_reg <= 1'b0;
      wide_reg <= 1'b1;
      sleep_reg <= 1'b0;
      lock_reg <= 1'b0;
      irq_reg <= 1'b0;
      dma_reg <= 1'b0;
    end else if (ena) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      write_reg <= write_next;
      mux_reg <= mux_next;
      wide_reg <= wide_next;
      sleep_reg <= sleep_next;
      lock_reg <= lock_next;
      irq_reg <= irq_next;
      dma_reg <= dma_next;
    end
  end

  // ****************************************
  // pin decode from the state flops
  // ****************************************
  logic in_cyc, strobe_on, drive_data, addr_phase;
  assign addr_phase = (state_reg == NLH_ADDR);
  assign in_cyc = addr_phase || (state_reg == NLH_SETUP) || (state_reg == NLH_STROBE) || (state_reg == NLH_HOLD);
  assign strobe_on = (state_reg == NLH_STROBE);
  assign drive_data = write_reg && in_cyc && !addr_phase;
  assign reset_in_n = (state_reg != NLH_RST);
  assign ce_n = !in_cyc;
  assign we_n = !(strobe_on && write_reg);
  assign oe_n = !(strobe_on && !write_reg);
  assign address_valid_n = !(addr_phase || (state_reg == NLH_MUXSEL));
  assign addr_hi = addr_reg[`NLH_ADDR_W-1:1];
  assign addr_lsb = wide_reg ? sleep_reg : addr_reg[0];
  assign if_cfg = wide_reg;
  assign lock_n = !lock_reg;
  // upper address lines are driven to zero; the device ignores them anyway
  assign ad_out = addr_phase ? {4'h0, addr_reg[`NLH_MUX_ADDR_HI+1:1]} : wdata_reg;
  assign ad_oe = addr_phase ? 16'hffff : (drive_data ? (wide_reg ? 16'hffff : 16'h00ff) : 16'h0000);
  assign req_ready = (state_reg == NLH_IDLE) && !sleep_reg && !sleep_req && ena;
  assign rsp_valid = (state_reg == NLH_HOLD) && cnt_done && ena;
  assign rsp_rdata = rdata_reg;
  assign dev_ready = (state_reg != NLH_RST) && (state_reg != NLH_BUSYW) && (state_reg != NLH_MUXSEL);
  assign irq_seen = irq_reg;
  assign dma_seen = dma_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b || !ena);
  sequence s_setup_end;
    (state_reg == NLH_SETUP) && cnt_done;
  endsequence
  sequence s_strobe_full;
    strobe_on[*3];
  endsequence
  a_write_qual: assert property (!we_n |-> !ce_n) else $error("write strobe without chip select");
  a_read_qual: assert property (!oe_n |-> !ce_n && ad_oe == 16'h0000) else $error("read strobe while driving");
  a_strobe_excl: assert property (!(!we_n && !oe_n)) else $error("both strobes low");
  a_strobe_len: assert property (s_setup_end |=> s_strobe_full ##1 !strobe_on) else $error("strobe width wrong");
  a_mux_addr: assert property (!address_valid_n && !ce_n |-> ad_out[11:0] == addr_reg[12:1] && ad_out[15:12] == 4'h0)
    else $error("mux address phase wrong");
  a_busy_hold: assert property (state_reg == NLH_BUSYW && !busy_n |=> ce_n && state_reg == NLH_BUSYW)
    else $error("access while busy");
  a_mux_edge_first: assert property ($fell(address_valid_n) && ce_n |-> reset_in_n && !dev_ready)
    else $error("mode edge out of order");
  a_dpd_share: assert property (wide_reg |-> addr_lsb == sleep_reg) else $error("deep sleep pin wrong");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid && (req_ready || sleep_reg || sleep_req))
    else $error("response not single");
endmodule
`default_nettype wire

// ---- hw/nlh_defs.svh ----
// timing and layout constants for the strobe-bus host port
`ifndef NLH_DEFS_SVH
`define NLH_DEFS_SVH
`define NLH_CLK_MHZ 40
`define NLH_ADDR_W 13
`define NLH_DATA_W 16
`define NLH_MUX_ADDR_HI 11
`define NLH_RST_PULSE_NS 1000
`define NLH_AVD_NS 25
`define NLH_SETUP_NS 10
`define NLH_ACCESS_NS 55
`define NLH_HOLD_NS 10
// least times round up to whole cycles
`define NLH_CYC(ns) (((ns) * `NLH_CLK_MHZ + 999) / 1000)
`endif

// ---- hw/nlh_pkg.sv ----
// state type for the strobe-bus host port
`default_nettype none
package nlh_pkg;
  typedef enum logic [3:0] {
    NLH_RST = 4'h0,
    NLH_BUSYW = 4'h1,
    NLH_MUXSEL = 4'h2,
    NLH_IDLE = 4'h3,
    NLH_ADDR = 4'h4,
    NLH_SETUP = 4'h5,
    NLH_STROBE = 4'h6,
    NLH_HOLD = 4'h7
  } nlh_state_t;
endpackage
`default_nettype wire

// ---- tb/nlh_dev_model.sv ----
// behavioural flash-disk device facing the strobe-bus host port
`default_nettype none
module nlh_dev_model #(
  parameter int BUSY_CYC = 4, // init length, kept short for the run
  parameter logic [11:0] PROT_BASE = 12'hf00, // first protected word
  parameter logic [1:0] DEV_ID = 2'b00 // cascade identity strapped on this device
) (
  input wire logic clk, // paces the busy count, the read latch and the multiplexed address capture
  input wire logic reset_in_n, // device reset
  input wire logic ce_n, // chip select
  input wire logic we_n, // write strobe
  input wire logic oe_n, // output strobe
  input wire logic identity_bit_hi, // tied to address_valid_n
  input wire logic [11:0] addr_hi, // plain address 12..1
  input wire logic if_cfg, // 1: 16-bit access
  input wire logic lock_n, // hardware lock
  input wire logic [15:0] bus, // resolved shared lines
  input wire logic irq_cmd, // long operation finished
  input wire logic dma_cmd, // dma service wanted
  output logic [15:0] dev_q, // device drive on shared lines
  output logic busy_n, // open-drain busy level
  output logic irq_n, // open-drain interrupt level
  output logic dma_request_n, // open-drain dma level
  output logic mux_mode // multiplexed mode entered
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:4095];
  logic [11:0] mux_addr;
  logic [15:0] last;
  logic viol;
  int bcnt;
  // multiplexed mode forces the upper identity bit low, leaving identities 0 and 1
  wire [1:0] id_eff = {DEV_ID[1] && !mux_mode, DEV_ID[0]};
  wire id_ok = (id_eff == 2'b00); // only the first cascade slot is fitted here
  wire [11:0] waddr = mux_mode ? mux_addr : addr_hi;
  wire rd = !ce_n && !oe_n && id_ok;
  // init count restarts on every reset
  always @(posedge clk) begin
    if (!reset_in_n) bcnt <= 0;
    else if (bcnt < BUSY_CYC) bcnt <= bcnt + 1;
    if (rd) last <= mem[waddr];
    if (!identity_bit_hi) mux_addr <= bus[11:0];
  end
  // any falling edge after reset release selects the shared bus; reset forgets it
  always @(negedge identity_bit_hi or negedge reset_in_n) begin
    if (!reset_in_n) mux_mode <= 1'b0;
    else mux_mode <= 1'b1;
  end
  // a locked protected word keeps its value and raises the interrupt until reset
  always @(posedge we_n or negedge reset_in_n) begin
    if (!reset_in_n) viol <= 1'b0;
    else if (!ce_n && id_ok) begin
      if (!lock_n && waddr >= PROT_BASE) viol <= 1'b1;
      else mem[waddr] <= if_cfg ? bus : {8'h00, bus[7:0]};
    end
  end
  // released lines show the inverse of the last read; narrow mode upper lines sit on pull-ups
  assign dev_q = rd ? mem[waddr] : (if_cfg ? ~last : {8'hff, ~last[7:0]});
  assign busy_n = bcnt >= BUSY_CYC;
  assign irq_n = !(irq_cmd || viol);
  assign dma_request_n = !dma_cmd;
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the strobe-bus host port
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst_b = 0, ena = 1, cfg_mux = 0, cfg_wide = 1, cfg_lock = 0, sleep_req = 0;
  logic req_valid = 0, req_write = 0, irq_cmd = 0, dma_cmd = 0;
  logic [12:0] req_addr = 13'h0000;
  logic [15:0] req_wdata = 16'h0000;
  wire logic req_ready, rsp_valid, dev_ready, irq_seen, dma_seen, reset_in_n, ce_n, we_n, oe_n;
  wire logic address_valid_n, addr_lsb, if_cfg, lock_n, busy_n, irq_n, dma_request_n, mux_mode;
  wire logic [11:0] addr_hi;
  wire logic [15:0] rsp_rdata, ad_out, ad_oe, ad_in, dev_q;
  int n_mismatch = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  // wire level: host bits where enabled, device drive elsewhere
  assign ad_in = (ad_oe & ad_out) | (~ad_oe & dev_q);
  nlh_host_port #(.RST_CYC(2)) u_dut (.clk(clk), .rst_b(rst_b), .ena(ena), .cfg_mux(cfg_mux),
    .cfg_wide(cfg_wide), .cfg_lock(cfg_lock), .sleep_req(sleep_req), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .dev_ready(dev_ready), .irq_seen(irq_seen),
    .dma_seen(dma_seen), .reset_in_n(reset_in_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .address_valid_n(address_valid_n), .addr_hi(addr_hi), .addr_lsb(addr_lsb), .if_cfg(if_cfg),
    .lock_n(lock_n), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in), .busy_n(busy_n), .irq_n(irq_n),
    .dma_request_n(dma_request_n));
  nlh_dev_model u_dev (.clk(clk), .reset_in_n(reset_in_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .identity_bit_hi(address_valid_n), .addr_hi(addr_hi), .if_cfg(if_cfg), .lock_n(lock_n),
    .bus(ad_in), .irq_cmd(irq_cmd), .dma_cmd(dma_cmd), .dev_q(dev_q), .busy_n(busy_n),
    .irq_n(irq_n), .dma_request_n(dma_request_n), .mux_mode(mux_mode));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #2;
  endtask
  // reset with a given bus shape, then wait for the host to see the device usable
  task automatic restart(input logic mux, input logic wide);
    int n;
    rst_b = 0;
    cfg_mux = mux;
    cfg_wide = wide;
    repeat (5) step();
    rst_b = 1;
    n = 0;
    while (!dev_ready && n < 200) begin
      if (!busy_n) chk(16'(dev_ready), 16'h0000);
      step();
      n++;
    end
    chk(16'(dev_ready), 16'h0001);
    chk(16'(mux_mode), 16'(mux));
    chk(16'(if_cfg), 16'(wide));
  endtask
  // one access; latency counted from the taking edge, lane enables seen mid-cycle
  task automatic acc(input logic w, input logic [12:0] a, input logic [15:0] d, input int lat);
    int n;
    logic [15:0] oe_mid;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    n = 0;
    while (!req_ready && n < 50) begin
      step();
      n++;
    end
    step();
    req_valid = 0;
    n = 0;
    while (!rsp_valid && n < 50) begin
      step();
      n++;
      if (n == 2) oe_mid = ad_oe;
    end
    chk(16'(n + 1), 16'(lat));
    chk(oe_mid, w ? (cfg_wide ? 16'hffff : 16'h00ff) : 16'h0000);
  endtask
  // hang guard, far above the hundred or so cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    restart(1'b0, 1'b1);
    acc(1'b1, 13'h0000, 16'ha5c3, 5);
    acc(1'b1, 13'h1ffe, 16'h5a3c, 5);
    acc(1'b1, 13'h1e00, 16'h1234, 5);
    acc(1'b0, 13'h1ffe, 16'h0000, 5);
    chk(rsp_rdata, 16'h5a3c);
    acc(1'b0, 13'h0000, 16'h0000, 5);
    chk(rsp_rdata, 16'ha5c3);
    irq_cmd = 1;
    dma_cmd = 1;
    step();
    chk(16'({irq_seen, dma_seen}), 16'h0003);
    irq_cmd = 0;
    dma_cmd = 0;
    cfg_lock = 1;
    step();
    chk(16'({irq_seen, dma_seen, lock_n}), 16'h0000);
    acc(1'b1, 13'h1e00, 16'hdead, 5);
    chk(rsp_rdata, 16'ha5c3);
    step();
    chk(16'(irq_seen), 16'h0001);
    acc(1'b0, 13'h1e00, 16'h0000, 5);
    chk(rsp_rdata, 16'h1234);
    sleep_req = 1;
    repeat (2) step();
    chk(16'(addr_lsb), 16'h0001);
    req_valid = 1;
    step();
    chk(16'(req_ready), 16'h0000);
    req_valid = 0;
    sleep_req = 0;
    cfg_lock = 0;
    step();
    chk(16'(addr_lsb), 16'h0000);
    // multiplexed 8-bit bus: one extra address cycle, upper byte dropped
    restart(1'b1, 1'b0);
    acc(1'b1, 13'h0044, 16'hbeef, 6);
    acc(1'b1, 13'h1ffe, 16'h7755, 6);
    acc(1'b0, 13'h0044, 16'h0000, 6);
    chk(rsp_rdata, 16'h00ef);
    acc(1'b0, 13'h1ffe, 16'h0000, 6);
    chk(rsp_rdata, 16'h0055);
    final_report();
  end
endmodule
`default_nettype wire
